/* logic/pmc_map.vh */
// Register offsets, field positions, reset values, mode codes and timing counts.
`ifndef PMC_MAP_VH
`define PMC_MAP_VH
`define PMC_OFS_CTRL 8'h00
`define PMC_OFS_CLKCFG 8'h04
`define PMC_OFS_STATUS 8'h08
`define PMC_OFS_BORCFG 8'h0c
`define PMC_OFS_BORSTAT 8'h10
`define PMC_OFS_TRIM 8'h14
`define PMC_MODE_RUN 3'h0
`define PMC_MODE_SLEEP 3'h1
`define PMC_MODE_STOP 3'h2
`define PMC_MODE_STANDBY 3'h3
`define PMC_MODE_SHUTDOWN 3'h4
`define PMC_CTRL_MODE_LSB 0
`define PMC_CTRL_POL_LSB 4
`define PMC_CTRL_GO_BIT 8
`define PMC_CLK_MSRC_BIT 0
`define PMC_CLK_HFSEL_LSB 1
`define PMC_CLK_MFEN_BIT 3
`define PMC_CLK_CONVEN_BIT 4
`define PMC_CLK_OUTEN_BIT 5
`define PMC_CLK_STOPHF_BIT 6
`define PMC_CLK_RESET 7'h00
`define PMC_TRIM_PAR_BIT 16
`define PMC_TRIM_RESET 17'h00000
`define PMC_BORCFG_RESET 12'h000
`define PMC_RATE_HF 2'h0
`define PMC_RATE_4M 2'h1
`define PMC_RATE_32K 2'h2
`define PMC_RATE_NONE 2'h3
`define PMC_CLK_NS 100
`define PMC_SEQ_NS 1000
`define PMC_SEQ_CYC 8'h0a
`endif

/* logic/pmc_ctrl.v */
// Power mode and clock distribution controller with APB register access.
//
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`include "pmc_map.vh"
module pmc_ctrl (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire periph_irq,
    input wire pd0_irq,
    input wire external_reset_pin_n,
    input wire debug_activity,
    input wire wake_pin_match,
    input wire fast_clock_req,
    input wire [2:0] bor_warn_cmp,
    output reg processor_clock_en,
    output reg main_clock_en,
    output reg main_clock_src_slow,
    output reg ultra_low_power_clock_en,
    output reg [1:0] ultra_low_power_clock_rate,
    output reg timer_clock_en,
    output reg [1:0] timer_clock_rate,
    output reg mid_freq_fixed_clock_en,
    output reg low_freq_fixed_clock_en,
    output reg converter_clock_en,
    output reg clock_out_en,
    output reg high_freq_internal_osc_en,
    output reg [1:0] high_freq_osc_sel,
    output reg low_freq_internal_osc_en,
    output reg high_perf_power_domain_en,
    output reg low_speed_power_domain_en,
    output reg high_perf_domain_retain,
    output reg domains_config_clear,
    output reg core_regulator_en,
    output reg [1:0] core_regulator_drive,
    output reg [11:0] bor_thresholds,
    output reg por_request
);

    localparam [4:0] ST_ACTIVE = 5'h01;
    localparam [4:0] ST_GATE = 5'h02;
    localparam [4:0] ST_PDOWN = 5'h04;
    localparam [4:0] ST_PUP = 5'h08;
    localparam [4:0] ST_UNGATE = 5'h10;
    localparam [7:0] SEQ_CYC = `PMC_SEQ_CYC;
    localparam NSYNC = 9;

    reg [4:0] state_r;
    reg [4:0] state_nxt;
    reg [2:0] clk_mode_r;
    reg [1:0] clk_pol_r;
    reg [2:0] pwr_mode_r;
    reg [2:0] tgt_mode_r;
    reg [1:0] tgt_pol_r;
    reg [1:0] run_pol_r;
    reg [7:0] wait_r;
    reg [6:0] clkcfg_r;
    reg [16:0] trim_r;
    reg [2:0] bor_flag_r;
    reg [NSYNC-1:0] s1_r;
    reg [NSYNC-1:0] s2_r;
    reg [NSYNC-1:0] s3_r;
    reg [NSYNC-1:0] filt_r;
    wire [NSYNC-1:0] async_in;
    wire setup;
    wire access;
    wire wr;
    wire go;
    wire wake;
    wire mapped;
    wire f_irq;
    wire f_pd0;
    wire f_rst_n;
    wire f_dbg;
    wire f_pin;
    wire f_fast;
    wire [2:0] f_bor;
    wire [2:0] req_mode;
    wire [1:0] req_pol;
    wire wait_done;

    // Rate of the peripheral clock for a mode and policy; stop policy zero follows the run policy.
    function [1:0] ulp_rate;
        input [2:0] mode;
        input [1:0] pol;
        input [1:0] rpol;
        begin
            case (mode)
                `PMC_MODE_RUN, `PMC_MODE_SLEEP: begin
                    ulp_rate = (pol == 2'd0) ? `PMC_RATE_HF : `PMC_RATE_32K;
                end
                `PMC_MODE_STOP: begin
                    if (pol == 2'd2) begin
                        ulp_rate = `PMC_RATE_32K;
                    end else if (pol == 2'd0 && rpol != 2'd0) begin
                        ulp_rate = `PMC_RATE_32K;
                    end else begin
                        ulp_rate = `PMC_RATE_4M;
                    end
                end
                `PMC_MODE_STANDBY: begin
                    ulp_rate = `PMC_RATE_32K;
                end
                default: begin
                    ulp_rate = `PMC_RATE_NONE;
                end
            endcase
        end
    endfunction

    // Fast oscillator demand for a mode and policy.
    function hf_on;
        input [2:0] mode;
        input [1:0] pol;
        input [1:0] rpol;
        input stop_keep;
        begin
            case (mode)
                `PMC_MODE_RUN, `PMC_MODE_SLEEP: begin
                    hf_on = (pol != 2'd2);
                end
                `PMC_MODE_STOP: begin
                    if (pol == 2'd0) begin
                        hf_on = (rpol == 2'd0) ? stop_keep : (rpol == 2'd1);
                    end else begin
                        hf_on = (pol == 2'd1);
                    end
                end
                default: begin
                    hf_on = 1'b0;
                end
            endcase
        end
    endfunction

    assign async_in = {periph_irq, pd0_irq, external_reset_pin_n, debug_activity,
                       wake_pin_match, fast_clock_req, bor_warn_cmp};

    // Three-stage synchroniser; a new level is accepted once stages two and three agree.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_r <= 9'h040;
            s2_r <= 9'h040;
            s3_r <= 9'h040;
            filt_r <= 9'h040;
        end else begin
            s1_r <= async_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            filt_r <= (s2_r & s3_r) | (filt_r & (s2_r | s3_r));
        end
    end

    assign f_irq = filt_r[8];
    assign f_pd0 = filt_r[7];
    assign f_rst_n = filt_r[6];
    assign f_dbg = filt_r[5];
    assign f_pin = filt_r[4];
    assign f_fast = filt_r[3];
    assign f_bor = filt_r[2:0];

    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign wr = access & pwrite;
    assign pready = 1'b1;
    assign mapped = (paddr == `PMC_OFS_CTRL) || (paddr == `PMC_OFS_CLKCFG) ||
                    (paddr == `PMC_OFS_STATUS) || (paddr == `PMC_OFS_BORCFG) ||
                    (paddr == `PMC_OFS_BORSTAT) || (paddr == `PMC_OFS_TRIM);
    assign pslverr = access & ~mapped;
    assign req_mode = pwdata[`PMC_CTRL_MODE_LSB+2:`PMC_CTRL_MODE_LSB];
    assign req_pol = pwdata[`PMC_CTRL_POL_LSB+1:`PMC_CTRL_POL_LSB];
    // Entry is taken only from steady run; a run request or an unknown mode code is ignored.
    assign go = wr && (paddr == `PMC_OFS_CTRL) && pwdata[`PMC_CTRL_GO_BIT] &&
                (state_r == ST_ACTIVE) && (clk_mode_r == `PMC_MODE_RUN) &&
                (req_mode != `PMC_MODE_RUN) && (req_mode <= `PMC_MODE_SHUTDOWN);
    assign wait_done = (wait_r == 8'h00);

    // Wake sources by mode: shutdown only listens to reset pin, debug and pin match.
    assign wake = (pwr_mode_r == `PMC_MODE_SLEEP) ? f_irq :
                  (pwr_mode_r == `PMC_MODE_STOP ||
                   pwr_mode_r == `PMC_MODE_STANDBY) ? (f_irq | f_pd0) :
                  (pwr_mode_r == `PMC_MODE_SHUTDOWN) ? (~f_rst_n | f_dbg | f_pin) :
                  1'b0;

    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_ACTIVE: begin
                if (go) begin
                    state_nxt = ST_GATE;
                end else if (wake && clk_mode_r != `PMC_MODE_RUN) begin
                    state_nxt = ST_PUP;
                end
            end
            ST_GATE: begin
                if (wait_done) begin
                    state_nxt = ST_PDOWN;
                end
            end
            ST_PDOWN: begin
                state_nxt = ST_ACTIVE;
            end
            ST_PUP: begin
                if (wait_done) begin
                    state_nxt = ST_UNGATE;
                end
            end
            ST_UNGATE: begin
                state_nxt = ST_ACTIVE;
            end
            default: begin
                state_nxt = ST_ACTIVE;
            end
        endcase
    end

    // Clocks move first on entry, power first on wake, with a settle time between.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_ACTIVE;
            clk_mode_r <= `PMC_MODE_RUN;
            clk_pol_r <= 2'd0;
            pwr_mode_r <= `PMC_MODE_RUN;
            tgt_mode_r <= `PMC_MODE_RUN;
            tgt_pol_r <= 2'd0;
            run_pol_r <= 2'd0;
            wait_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            if (wait_r != 8'h00) begin
                wait_r <= wait_r - 8'h01;
            end
            case (state_r)
                ST_ACTIVE: begin
                    if (go) begin
                        tgt_mode_r <= req_mode;
                        tgt_pol_r <= (req_mode == `PMC_MODE_STANDBY && req_pol > 2'd1) ?
                                     2'd1 : req_pol;
                        clk_mode_r <= req_mode;
                        clk_pol_r <= req_pol;
                        wait_r <= SEQ_CYC;
                    end else if (wake && clk_mode_r != `PMC_MODE_RUN) begin
                        pwr_mode_r <= `PMC_MODE_RUN;
                        wait_r <= SEQ_CYC;
                    end else if (wr && paddr == `PMC_OFS_CTRL &&
                                 clk_mode_r == `PMC_MODE_RUN &&
                                 req_mode == `PMC_MODE_RUN && req_pol != 2'd3) begin
                        clk_pol_r <= req_pol;
                        run_pol_r <= req_pol;
                    end
                end
                ST_GATE: begin
                    if (tgt_mode_r == `PMC_MODE_STANDBY) begin
                        clk_pol_r <= tgt_pol_r;
                    end
                    if (wait_done) begin
                        pwr_mode_r <= tgt_mode_r;
                    end
                end
                ST_PUP: begin
                    if (wait_done) begin
                        clk_mode_r <= `PMC_MODE_RUN;
                        clk_pol_r <= run_pol_r;
                    end
                end
            endcase
        end
    end

    // Register file, brownout flags and trim parity watch.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clkcfg_r <= `PMC_CLK_RESET;
            trim_r <= `PMC_TRIM_RESET;
            bor_thresholds <= `PMC_BORCFG_RESET;
            bor_flag_r <= 3'h0;
            por_request <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            // Flags set by a comparator win over a clear in the same cycle.
            bor_flag_r <= (bor_flag_r & ~((wr && paddr == `PMC_OFS_BORSTAT) ?
                          pwdata[2:0] : 3'h0)) | f_bor;
            por_request <= por_request | (^trim_r);
            if (wr && paddr == `PMC_OFS_CLKCFG) begin
                clkcfg_r <= pwdata[6:0];
            end
            if (wr && paddr == `PMC_OFS_TRIM) begin
                trim_r <= pwdata[16:0];
            end
            if (wr && paddr == `PMC_OFS_BORCFG) begin
                bor_thresholds <= pwdata[11:0];
            end
            if (setup) begin
                if (paddr == `PMC_OFS_CTRL) begin
                    prdata <= {26'h0, clk_pol_r, 1'b0, clk_mode_r};
                end else if (paddr == `PMC_OFS_CLKCFG) begin
                    prdata <= {25'h0, clkcfg_r};
                end else if (paddr == `PMC_OFS_STATUS) begin
                    prdata <= {16'h0, 3'h0, state_r, 2'h0, run_pol_r, 1'b0, pwr_mode_r};
                end else if (paddr == `PMC_OFS_BORCFG) begin
                    prdata <= {20'h0, bor_thresholds};
                end else if (paddr == `PMC_OFS_BORSTAT) begin
                    prdata <= {29'h0, bor_flag_r};
                end else if (paddr == `PMC_OFS_TRIM) begin
                    prdata <= {15'h0, trim_r};
                end else begin
                    prdata <= 32'h00000000;
                end
            end
        end
    end

    // Clock and power outputs decoded from the clock-side and power-side modes.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            processor_clock_en <= 1'b1;
            main_clock_en <= 1'b1;
            main_clock_src_slow <= 1'b0;
            ultra_low_power_clock_en <= 1'b1;
            ultra_low_power_clock_rate <= `PMC_RATE_HF;
            timer_clock_en <= 1'b1;
            timer_clock_rate <= `PMC_RATE_HF;
            mid_freq_fixed_clock_en <= 1'b0;
            low_freq_fixed_clock_en <= 1'b1;
            converter_clock_en <= 1'b0;
            clock_out_en <= 1'b0;
            high_freq_internal_osc_en <= 1'b1;
            high_freq_osc_sel <= 2'h0;
            low_freq_internal_osc_en <= 1'b1;
            high_perf_power_domain_en <= 1'b1;
            low_speed_power_domain_en <= 1'b1;
            high_perf_domain_retain <= 1'b0;
            domains_config_clear <= 1'b0;
            core_regulator_en <= 1'b1;
            core_regulator_drive <= 2'h2;
        end else begin
            processor_clock_en <= (clk_mode_r == `PMC_MODE_RUN);
            main_clock_en <= (clk_mode_r <= `PMC_MODE_SLEEP);
            main_clock_src_slow <= (clk_pol_r != 2'd0) | clkcfg_r[`PMC_CLK_MSRC_BIT];
            ultra_low_power_clock_en <= (clk_mode_r <= `PMC_MODE_STANDBY) &&
                !(clk_mode_r == `PMC_MODE_STANDBY && clk_pol_r == 2'd1 && !f_fast);
            ultra_low_power_clock_rate <= ulp_rate(clk_mode_r, clk_pol_r, run_pol_r);
            timer_clock_en <= (clk_mode_r <= `PMC_MODE_STANDBY);
            timer_clock_rate <= ulp_rate(clk_mode_r, clk_pol_r, run_pol_r);
            mid_freq_fixed_clock_en <= clkcfg_r[`PMC_CLK_MFEN_BIT] &&
                ((clk_mode_r <= `PMC_MODE_SLEEP && clk_pol_r == 2'd0) ||
                 (clk_mode_r == `PMC_MODE_STOP && clk_pol_r != 2'd2));
            low_freq_fixed_clock_en <= (clk_mode_r <= `PMC_MODE_STANDBY);
            converter_clock_en <= clkcfg_r[`PMC_CLK_CONVEN_BIT] &&
                (clk_mode_r <= `PMC_MODE_STOP);
            clock_out_en <= clkcfg_r[`PMC_CLK_OUTEN_BIT] &&
                (clk_mode_r <= `PMC_MODE_STANDBY);
            high_freq_internal_osc_en <= hf_on(clk_mode_r, clk_pol_r, run_pol_r,
                clkcfg_r[`PMC_CLK_STOPHF_BIT]);
            high_freq_osc_sel <= clkcfg_r[`PMC_CLK_HFSEL_LSB+1:`PMC_CLK_HFSEL_LSB];
            low_freq_internal_osc_en <= (pwr_mode_r != `PMC_MODE_SHUTDOWN);
            high_perf_power_domain_en <= (pwr_mode_r <= `PMC_MODE_SLEEP);
            low_speed_power_domain_en <= (pwr_mode_r <= `PMC_MODE_STANDBY);
            high_perf_domain_retain <= (pwr_mode_r == `PMC_MODE_STOP) ||
                (pwr_mode_r == `PMC_MODE_STANDBY);
            domains_config_clear <= (pwr_mode_r == `PMC_MODE_SHUTDOWN);
            core_regulator_en <= (pwr_mode_r != `PMC_MODE_SHUTDOWN);
            core_regulator_drive <= (pwr_mode_r <= `PMC_MODE_SLEEP) ? 2'h2 :
                (pwr_mode_r == `PMC_MODE_STOP) ? 2'h1 : 2'h0;
        end
    end

endmodule // pmc_ctrl

/* dv/pmc_ctrl_asserts.sv */
// Port-level checker for the power mode and clock controller.
`timescale 1ns/100ps
module pmc_ctrl_asserts (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire pready,
    input wire pslverr,
    input wire processor_clock_en,
    input wire main_clock_en,
    input wire high_perf_power_domain_en,
    input wire low_speed_power_domain_en,
    input wire ultra_low_power_clock_en,
    input wire converter_clock_en,
    input wire core_regulator_en,
    input wire por_request
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_zero_wait: assert property (psel && penable |-> pready)
        else $error("access cycle without ready");
    a_slverr_map: assert property (psel && penable && paddr[1:0] == 2'b00
        |-> pslverr == (paddr > 8'h14)) else $error("error response wrong for address");
    a_cpu_needs_main: assert property (processor_clock_en
        |-> main_clock_en && high_perf_power_domain_en) else $error("processor clock alone");
    a_main_needs_pd: assert property (main_clock_en |-> high_perf_power_domain_en)
        else $error("main clock without power");
    a_ulp_conv_pd: assert property (ultra_low_power_clock_en || converter_clock_en
        |-> low_speed_power_domain_en) else $error("low speed clock without power");
    a_shutdown_all: assert property (!low_speed_power_domain_en
        |-> !core_regulator_en && !high_perf_power_domain_en) else $error("partial shutdown");
    a_gate_first: assert property ($fell(high_perf_power_domain_en)
        |-> !$past(main_clock_en, 5) && !processor_clock_en) else $error("power cut under clock");
    a_power_first: assert property ($rose(main_clock_en)
        |-> $past(high_perf_power_domain_en, 5)) else $error("clock before power");
    a_trim_parity: assert property (psel && penable && pwrite && paddr == 8'h14
        && ^pwdata[16:0] |-> ##[1:2] por_request) else $error("parity error missed");
    c_pd_off: cover property ($fell(high_perf_power_domain_en));
    c_shutdown: cover property ($fell(low_speed_power_domain_en));
    c_wake: cover property ($rose(processor_clock_en));
    c_por: cover property ($rose(por_request));
endmodule // pmc_ctrl_asserts

bind pmc_ctrl pmc_ctrl_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .processor_clock_en(processor_clock_en), .main_clock_en(main_clock_en),
    .high_perf_power_domain_en(high_perf_power_domain_en),
    .low_speed_power_domain_en(low_speed_power_domain_en),
    .ultra_low_power_clock_en(ultra_low_power_clock_en),
    .converter_clock_en(converter_clock_en), .core_regulator_en(core_regulator_en),
    .por_request(por_request));

/* dv/pmc_periph_model.sv */
// Peripheral side model that raises wake interrupts and clears them once serviced.
`timescale 1ns/100ps
module pmc_periph_model (
    input wire pclk,
    input wire presetn,
    input wire processor_clock_en,
    input wire [1:0] wake_req,
    output logic periph_irq,
    output logic pd0_irq
);
    // An interrupt stays pending until the processor runs again to service it.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            periph_irq <= 1'b0;
            pd0_irq <= 1'b0;
        end else begin
            if (wake_req[0]) periph_irq <= 1'b1;
            else if (processor_clock_en) periph_irq <= 1'b0;
            if (wake_req[1]) pd0_irq <= 1'b1;
            else if (processor_clock_en) pd0_irq <= 1'b0;
        end
    end
endmodule // pmc_periph_model

/* dv/power_mode_clock_controller_tb.sv */
// Self-checking bench for the power mode and clock controller.
`timescale 1ns/100ps
`include "pmc_map.vh"
module power_mode_clock_controller_tb;
logic pclk, presetn, psel, penable, pwrite, err, external_reset_pin_n, debug_activity;
logic wake_pin_match, fast_clock_req;
logic [7:0] paddr;
logic [31:0] pwdata, rd, cfg, v;
logic [2:0] bor_warn_cmp;
logic [1:0] wake_req;
wire [31:0] prdata;
wire pready, pslverr, periph_irq, pd0_irq, processor_clock_en, main_clock_en, clock_out_en;
wire main_clock_src_slow, ultra_low_power_clock_en, timer_clock_en, mid_freq_fixed_clock_en;
wire low_freq_fixed_clock_en, converter_clock_en, high_freq_internal_osc_en, por_request;
wire low_freq_internal_osc_en, high_perf_power_domain_en, low_speed_power_domain_en;
wire high_perf_domain_retain, domains_config_clear, core_regulator_en;
wire [1:0] ultra_low_power_clock_rate, timer_clock_rate, high_freq_osc_sel, core_regulator_drive;
wire [11:0] bor_thresholds;
wire [10:0] got = {processor_clock_en, main_clock_en, high_perf_power_domain_en,
    low_speed_power_domain_en, low_freq_internal_osc_en, core_regulator_en, converter_clock_en,
    mid_freq_fixed_clock_en, clock_out_en, high_perf_domain_retain, domains_config_clear};
integer n_errors, n_checks, cyc, seed, m, md, i;
pmc_ctrl dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .periph_irq, .pd0_irq, .external_reset_pin_n, .debug_activity, .wake_pin_match,
    .fast_clock_req, .bor_warn_cmp, .processor_clock_en, .main_clock_en, .main_clock_src_slow,
    .ultra_low_power_clock_en, .ultra_low_power_clock_rate, .timer_clock_en, .timer_clock_rate,
    .mid_freq_fixed_clock_en, .low_freq_fixed_clock_en, .converter_clock_en, .clock_out_en,
    .high_freq_internal_osc_en, .high_freq_osc_sel, .low_freq_internal_osc_en,
    .high_perf_power_domain_en, .low_speed_power_domain_en, .high_perf_domain_retain,
    .domains_config_clear, .core_regulator_en, .core_regulator_drive, .bor_thresholds,
    .por_request);
pmc_periph_model u_far (.pclk, .presetn, .processor_clock_en, .wake_req, .periph_irq,
    .pd0_irq);
initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
end
// Expected enables with mid, converter and clock-out configured on.
function automatic logic [10:0] exp_vec(input integer m);
    exp_vec = {m == 0, m <= 1, m <= 1, m != 4, m != 4, m != 4, m <= 2, m <= 2, m <= 3,
        m == 2 || m == 3, m == 4};
endfunction
// Expected slow fixed clock, regulator drive and timer clock rate after entry with policy 0.
function automatic logic [4:0] exp_aux(input integer m);
    exp_aux = {m <= 3, (m <= 1) ? 2'h2 : (m == 2) ? 2'h1 : 2'h0,
        (m <= 1) ? 2'h0 : (m == 2) ? 2'h1 : (m == 3) ? 2'h2 : 2'h3};
endfunction
task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    begin
        n_checks = n_checks + 1;
        if (g !== e) begin
            n_errors = n_errors + 1;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    end
endtask
task results;
    begin
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    end
endtask
task wt(input integer n);
    repeat (n) @(posedge pclk);
endtask
task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    begin
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    end
endtask
task enter(input integer md, input integer pol);
    begin
        apb(1'b1, `PMC_OFS_CTRL, 32'h100 | (pol << 4) | md);
        wt(30);
    end
endtask
task wk(input logic [1:0] w);
    begin
        wake_req <= w;
        wt(1);
        wake_req <= 2'b00;
        wt(30);
    end
endtask
task tend(input string nm);
    $display("test %s done, mismatches so far %0d", nm, n_errors);
endtask
always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
        n_errors = n_errors + 1;
        results();
    end
end
initial begin
    seed = 32'h29b2;
    {n_errors, n_checks, cyc} = 0;
    {psel, penable, pwrite, paddr, pwdata, debug_activity, wake_pin_match} = 0;
    {fast_clock_req, bor_warn_cmp, wake_req, presetn} = 0;
    external_reset_pin_n = 1'b1;
    wt(2);
    presetn <= 1'b1;
    wt(1);
    chk("reset enables", exp_vec(0) & 11'h7e3, got);
    chk("reset drive por", 3'h2, {por_request, core_regulator_drive});
    apb(1'b0, 8'h40, 0);
    chk("unmapped err", 1, err);
    chk("unmapped data", 0, rd);
    apb(1'b1, `PMC_OFS_STATUS, 32'hffff);
    apb(1'b0, `PMC_OFS_STATUS, 0);
    chk("status", 32'h100, rd);
    cfg = ($random(seed) & 32'h6) | 32'h38;
    apb(1'b1, `PMC_OFS_CLKCFG, cfg);
    apb(1'b0, `PMC_OFS_CLKCFG, 0);
    chk("clkcfg", cfg, rd);
    chk("osc select", cfg[2:1], high_freq_osc_sel);
    v = $random(seed);
    apb(1'b1, `PMC_OFS_BORCFG, v);
    apb(1'b0, `PMC_OFS_BORCFG, 0);
    chk("borcfg", v & 32'hfff, rd);
    chk("thresholds", v[11:0], bor_thresholds);
    bor_warn_cmp <= 3'h5;
    wt(6);
    bor_warn_cmp <= 3'h0;
    wt(6);
    apb(1'b0, `PMC_OFS_BORSTAT, 0);
    chk("warn sticky", 3'h5, rd);
    apb(1'b1, `PMC_OFS_BORSTAT, 32'h7);
    apb(1'b0, `PMC_OFS_BORSTAT, 0);
    chk("warn clear", 0, rd);
    tend("registers");
    for (m = 1; m <= 6; m = m + 1) begin
        md = (m > 4) ? 4 : m;
        enter(md, 0);
        chk("mode enables", exp_vec(md), got);
        chk("mode aux", exp_aux(md),
            {low_freq_fixed_clock_en, core_regulator_drive, timer_clock_rate});
        if (md == 4) begin
            wk(2'b01);
            chk("shutdown holds", exp_vec(4), got);
            if (m == 4) external_reset_pin_n <= 1'b0;
            else if (m == 5) debug_activity <= 1'b1;
            else wake_pin_match <= 1'b1;
            wk(2'b00);
            {debug_activity, wake_pin_match} <= 2'b00;
            external_reset_pin_n <= 1'b1;
        end else wk((md == 1) ? 2'b01 : 2'b10);
        chk("woken", exp_vec(0) & 11'h7e3, got & 11'h7e3);
        apb(1'b0, `PMC_OFS_STATUS, 0);
        chk("status run", 32'h100, rd & 32'h1f37);
        if (m == 3) begin
            apb(1'b0, `PMC_OFS_CLKCFG, 0);
            chk("config kept", cfg, rd);
        end
    end
    tend("modes");
    for (i = 1; i <= 2; i = i + 1) begin
        apb(1'b1, `PMC_OFS_CTRL, i << 4);
        wt(3);
        chk("slow main", 1, main_clock_src_slow);
        enter(2, 0);
        chk("stop_policy_first osc rate", {i == 1, 2'h2},
            {high_freq_internal_osc_en, ultra_low_power_clock_rate});
        wk(2'b10);
    end
    apb(1'b1, `PMC_OFS_CTRL, 0);
    wt(3);
    enter(3, 1);
    chk("standby_policy_second clocks", 2'b10, {timer_clock_en, ultra_low_power_clock_en});
    fast_clock_req <= 1'b1;
    wt(8);
    chk("fast request", 1, ultra_low_power_clock_en);
    fast_clock_req <= 1'b0;
    wk(2'b10);
    tend("policies");
    for (i = 0; i <= 1; i = i + 1) begin
        v = $random(seed) & 32'h1ffff;
        if (^v[16:0] != i[0]) v[16] = ~v[16];
        apb(1'b1, `PMC_OFS_TRIM, v);
        wt(3);
        chk("parity por", i[0], por_request);
    end
    presetn <= 1'b0;
    wt(2);
    presetn <= 1'b1;
    wt(1);
    chk("por cleared", 0, por_request);
    chk("rerun enables", exp_vec(0) & 11'h7e3, got);
    tend("trim");
    results();
end
endmodule // power_mode_clock_controller_tb
